// *** design/qelt_pkg.sv ***
// Package for the encoder line trigger block.
// Assumes a 50 MHz clock and one design module that uses it.
package qelt_pkg;

    // ------------------------------------------------------------
    // Clock and timing
    // ------------------------------------------------------------
    localparam int CLK_MHZ = 50;
    localparam int CLK_PERIOD_NS = 20;
    localparam int FILTER_MAX_NS = 150;
    localparam int FILTER_MAX_CYC = FILTER_MAX_NS / CLK_PERIOD_NS;
    localparam int STROBE_MIN_NS = 10;
    localparam int STROBE_MAX_NS = 2550;
    localparam int STROBE_MIN_CYC =
        (STROBE_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int STROBE_MAX_CYC = STROBE_MAX_NS / CLK_PERIOD_NS;

    // ------------------------------------------------------------
    // Register offsets
    // ------------------------------------------------------------
    localparam logic [3:0] OFS_SOURCES = 4'h0;
    localparam logic [3:0] OFS_METHOD = 4'h1;
    localparam logic [3:0] OFS_DIVIDER = 4'h2;
    localparam logic [3:0] OFS_SKIP = 4'h3;
    localparam logic [3:0] OFS_POLICY = 4'h4;
    localparam logic [3:0] OFS_FILTER = 4'h5;
    localparam logic [3:0] OFS_STROBE = 4'h6;
    localparam logic [3:0] OFS_AVERAGE = 4'h7;
    localparam logic [3:0] OFS_MAXIVAL = 4'h8;
    localparam logic [3:0] OFS_MASKED = 4'h9;
    localparam logic [3:0] OFS_STATUS = 4'hA;

    // ------------------------------------------------------------
    // Field positions and reset values
    // ------------------------------------------------------------
    localparam int SRC_ONE_LSB = 0;
    localparam int SRC_TWO_LSB = 4;
    localparam logic [2:0] RST_SRC_ONE = 3'h0;
    localparam logic [2:0] RST_SRC_TWO = 3'h2;
    localparam logic [31:0] RST_DIVIDER = 32'h0001_0000;
    localparam logic [15:0] DIV_FRAC_MASK = 16'hFFFF;
    localparam logic [15:0] RST_SKIP = 16'h0000;
    localparam logic [2:0] RST_FILTER = 3'h0;
    localparam logic [6:0] RST_STROBE = 7'h05;
    localparam logic [2:0] RST_AVERAGE = 3'h0;
    localparam logic [31:0] RST_MAXIVAL = 32'h0000_0000;
    localparam int NUM_INPUT_LINES = 5;

    // ------------------------------------------------------------
    // Modes
    // ------------------------------------------------------------
    typedef enum logic [0:0] {
        METHOD_RATIO,
        METHOD_SKIP
    } qelt_method_type;

    typedef enum logic [1:0] {
        POLICY_MOTION,
        POLICY_FORWARD,
        POLICY_BACKWARD
    } qelt_policy_type;

    typedef struct packed {
        logic [3:0] addr;
        logic [31:0] wdata;
        logic wr;
        logic rd;
    } qelt_bus_req_type;

endpackage

// *** design/qelt_trigger.sv ***
// Encoder to line trigger logic with a plain register port.
// Assumes encoder lines are asynchronous inputs, a 50 MHz clock, no bus waits.
// ----------------------------------------------------------------
// ----------------------------------------------------------------
//
// Chosen here: the address map and the plain strobed port.
`timescale 1ns/100ps
module qelt_trigger #(
    parameter int IVAL_W = 24,
    parameter int AVG_MAX = 8,
    parameter int MASK_W = 16
) (
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_reset,
    // Trigger-capable input lines
    input wire logic [qelt_pkg::NUM_INPUT_LINES-1:0] i_lines,
    // Register port
    input wire logic [3:0] i_addr,
    input wire logic [31:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    output logic [31:0] o_rdata,
    // Trigger output
    output logic o_trigger,
    output logic o_direction
);

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    qelt_pkg::qelt_bus_req_type req;
    logic [2:0] phase_one_input_select, phase_two_input_select;
    qelt_pkg::qelt_method_type trigger_method_select;
    logic [31:0] ratio_divider;
    logic [15:0] edges_to_skip;
    qelt_pkg::qelt_policy_type output_direction_policy;
    logic [2:0] input_glitch_filter;
    logic [6:0] trigger_pulse_width;
    logic [2:0] interval_averaging_depth;
    logic [31:0] max_interval;
    logic [MASK_W-1:0] suppressed_pulse_count;

    assign req = '{addr: i_addr, wdata: i_wdata, wr: i_wr, rd: i_rd};

    function automatic logic pick_line(
        input logic [qelt_pkg::NUM_INPUT_LINES-1:0] lines,
        input logic [2:0] sel);
        pick_line = (int'(sel) < qelt_pkg::NUM_INPUT_LINES) ?
            lines[sel] : 1'b0;
    endfunction

    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            phase_one_input_select <= qelt_pkg::RST_SRC_ONE;
            phase_two_input_select <= qelt_pkg::RST_SRC_TWO;
            trigger_method_select <= qelt_pkg::METHOD_RATIO;
            ratio_divider <= qelt_pkg::RST_DIVIDER;
            edges_to_skip <= qelt_pkg::RST_SKIP;
            output_direction_policy <= qelt_pkg::POLICY_MOTION;
            input_glitch_filter <= qelt_pkg::RST_FILTER;
            trigger_pulse_width <= qelt_pkg::RST_STROBE;
            interval_averaging_depth <= qelt_pkg::RST_AVERAGE;
            max_interval <= qelt_pkg::RST_MAXIVAL;
        end else if (req.wr) begin
            unique case (req.addr)
                qelt_pkg::OFS_SOURCES: begin
                    phase_one_input_select <=
                        req.wdata[qelt_pkg::SRC_ONE_LSB +: 3];
                    phase_two_input_select <=
                        req.wdata[qelt_pkg::SRC_TWO_LSB +: 3];
                end
                qelt_pkg::OFS_METHOD: trigger_method_select <=
                    qelt_pkg::qelt_method_type'(req.wdata[0]);
                qelt_pkg::OFS_DIVIDER: ratio_divider <= req.wdata;
                qelt_pkg::OFS_SKIP: edges_to_skip <= req.wdata[15:0];
                qelt_pkg::OFS_POLICY: output_direction_policy <=
                    (req.wdata[1:0] == 2'h3) ? qelt_pkg::POLICY_MOTION :
                    qelt_pkg::qelt_policy_type'(req.wdata[1:0]);
                qelt_pkg::OFS_FILTER: input_glitch_filter <=
                    (req.wdata[2:0] > 3'(qelt_pkg::FILTER_MAX_CYC)) ?
                    3'(qelt_pkg::FILTER_MAX_CYC) : req.wdata[2:0];
                qelt_pkg::OFS_STROBE: trigger_pulse_width <=
                    (req.wdata[6:0] < 7'(qelt_pkg::STROBE_MIN_CYC)) ?
                    7'(qelt_pkg::STROBE_MIN_CYC) : req.wdata[6:0];
                qelt_pkg::OFS_AVERAGE:
                    interval_averaging_depth <= req.wdata[2:0];
                qelt_pkg::OFS_MAXIVAL: max_interval <= req.wdata;
                default: ;
            endcase
        end
    end

    // Read data valid the cycle after the strobe only
    logic [31:0] next_rdata;
    always_comb begin
        next_rdata = 32'h0000_0000;
        if (req.rd) begin
            unique case (req.addr)
                qelt_pkg::OFS_SOURCES: begin
                    next_rdata[qelt_pkg::SRC_ONE_LSB +: 3] =
                        phase_one_input_select;
                    next_rdata[qelt_pkg::SRC_TWO_LSB +: 3] =
                        phase_two_input_select;
                end
                qelt_pkg::OFS_METHOD:
                    next_rdata[0] = trigger_method_select;
                qelt_pkg::OFS_DIVIDER: next_rdata = ratio_divider;
                qelt_pkg::OFS_SKIP: next_rdata[15:0] = edges_to_skip;
                qelt_pkg::OFS_POLICY:
                    next_rdata[1:0] = output_direction_policy;
                qelt_pkg::OFS_FILTER: next_rdata[2:0] = input_glitch_filter;
                qelt_pkg::OFS_STROBE: next_rdata[6:0] = trigger_pulse_width;
                qelt_pkg::OFS_AVERAGE:
                    next_rdata[2:0] = interval_averaging_depth;
                qelt_pkg::OFS_MAXIVAL: next_rdata = max_interval;
                qelt_pkg::OFS_MASKED:
                    next_rdata[MASK_W-1:0] = suppressed_pulse_count;
                qelt_pkg::OFS_STATUS: next_rdata[0] = o_direction;
                default: next_rdata = 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_reset) o_rdata <= 32'h0000_0000;
        else o_rdata <= next_rdata;
    end

    // ------------------------------------------------------------
    // Synchroniser and glitch filter
    // ------------------------------------------------------------
    // Two flops per phase; stage one feeds only stage two
    logic [1:0] sync_a, sync_b, filt, filt_d;
    logic [2:0] stab_a, stab_b;
    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            sync_a <= 2'h0;
            sync_b <= 2'h0;
        end else begin
            sync_a <= {sync_a[0],
                pick_line(i_lines, phase_one_input_select)};
            sync_b <= {sync_b[0],
                pick_line(i_lines, phase_two_input_select)};
        end
    end

    // Level accepted after it holds for the filter count
    logic [1:0] next_filt;
    logic [2:0] next_stab_a, next_stab_b;
    always_comb begin
        next_filt = filt;
        next_stab_a = 3'h0;
        next_stab_b = 3'h0;
        if (sync_a[1] != filt[0]) begin
            next_stab_a = stab_a + 3'h1;
            if (stab_a >= input_glitch_filter) begin
                next_filt[0] = sync_a[1];
                next_stab_a = 3'h0;
            end
        end
        if (sync_b[1] != filt[1]) begin
            next_stab_b = stab_b + 3'h1;
            if (stab_b >= input_glitch_filter) begin
                next_filt[1] = sync_b[1];
                next_stab_b = 3'h0;
            end
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            filt <= 2'h0;
            filt_d <= 2'h0;
            stab_a <= 3'h0;
            stab_b <= 3'h0;
        end else begin
            filt <= next_filt;
            filt_d <= filt;
            stab_a <= next_stab_a;
            stab_b <= next_stab_b;
        end
    end

    // ------------------------------------------------------------
    // Quadrature decode and direction masking
    // ------------------------------------------------------------
    logic any_edge, step_fwd, rise_a, pass_step;
    assign any_edge = (filt != filt_d);
    // A leads B forward: new A differs from old B
    assign step_fwd = (filt[0] ^ filt_d[1]);
    assign rise_a = filt[0] & ~filt_d[0];

    logic wanted, against;
    logic [MASK_W-1:0] next_masked;
    always_comb begin
        wanted = (output_direction_policy == qelt_pkg::POLICY_FORWARD) ?
            step_fwd : ~step_fwd;
        against = any_edge && !wanted;
        next_masked = suppressed_pulse_count;
        pass_step = 1'b0;
        if (output_direction_policy == qelt_pkg::POLICY_MOTION) begin
            next_masked = '0;
            pass_step = any_edge;
        end else if (against) begin
            if (~&suppressed_pulse_count)
                next_masked = suppressed_pulse_count + 1'b1;
        end else if (any_edge) begin
            if (suppressed_pulse_count != '0)
                next_masked = suppressed_pulse_count - 1'b1;
            else
                pass_step = 1'b1;
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            suppressed_pulse_count <= '0;
            o_direction <= 1'b1;
        end else begin
            suppressed_pulse_count <= next_masked;
            if (any_edge) o_direction <= step_fwd;
        end
    end

    // Phase one rise counts in ratio mode only when allowed
    logic a_pulse, edge_pulse;
    assign a_pulse = rise_a && pass_step;
    assign edge_pulse = pass_step;

    // ------------------------------------------------------------
    // Interval measurement and averaging
    // ------------------------------------------------------------
    // Cap prevents a stale standstill interval freezing triggers
    localparam logic [IVAL_W-1:0] IVAL_CAP = '1;
    logic [IVAL_W-1:0] ival_cnt, ival_hist [AVG_MAX];
    logic [IVAL_W+2:0] ival_sum;
    logic [IVAL_W-1:0] period_avg, cap_ival;
    logic [3:0] avg_n;
    logic is_whole;
    assign is_whole = (ratio_divider[15:0] == 16'h0000);

    always_comb begin
        cap_ival = IVAL_CAP;
        if (!is_whole && max_interval != 32'h0000_0000 &&
            max_interval < 32'(IVAL_CAP))
            cap_ival = max_interval[IVAL_W-1:0];
        avg_n = (interval_averaging_depth == 3'h0) ? 4'h1 :
            {1'b0, interval_averaging_depth};
        ival_sum = '0;
        for (int k = 0; k < AVG_MAX; k++)
            if (k < int'(avg_n))
                ival_sum = ival_sum + (IVAL_W+3)'(ival_hist[k]);
        period_avg = IVAL_W'(ival_sum / (IVAL_W+3)'(avg_n));
    end

    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            ival_cnt <= '0;
            for (int k = 0; k < AVG_MAX; k++) ival_hist[k] <= '0;
        end else if (a_pulse) begin
            ival_cnt <= IVAL_W'(1);
            ival_hist[0] <= ival_cnt;
            for (int k = 1; k < AVG_MAX; k++) ival_hist[k] <= ival_hist[k-1];
        end else if (ival_cnt < cap_ival) begin
            ival_cnt <= ival_cnt + 1'b1;
        end
    end

    // ------------------------------------------------------------
    // Trigger generation
    // ------------------------------------------------------------
    logic [15:0] dec_cnt, skip_cnt;
    logic [IVAL_W+15:0] acc, step_len;
    logic fire;
    logic [15:0] next_dec_cnt, next_skip_cnt;
    logic [IVAL_W+15:0] next_acc;

    // Spacing is period*divider/65536, in whole clock cycles
    assign step_len = (IVAL_W+16)'(((IVAL_W+32)'(period_avg) *
        (IVAL_W+32)'(ratio_divider)) >> 16);

    always_comb begin
        next_dec_cnt = dec_cnt;
        next_skip_cnt = skip_cnt;
        next_acc = acc;
        fire = 1'b0;
        if (trigger_method_select == qelt_pkg::METHOD_SKIP) begin
            if (edge_pulse) begin
                if (skip_cnt >= edges_to_skip) begin
                    fire = 1'b1;
                    next_skip_cnt = 16'h0000;
                end else
                    next_skip_cnt = skip_cnt + 16'h0001;
            end
        end else if (is_whole) begin
            if (a_pulse) begin
                if (dec_cnt + 16'h0001 >= ratio_divider[31:16]) begin
                    fire = 1'b1;
                    next_dec_cnt = 16'h0000;
                end else
                    next_dec_cnt = dec_cnt + 16'h0001;
            end
        end else begin
            if (a_pulse) begin
                fire = 1'b1;
                next_acc = '0;
            end else if (acc + (IVAL_W+16)'(1) >= step_len &&
                step_len != '0 && ival_cnt < period_avg) begin
                fire = 1'b1;
                next_acc = '0;
            end else
                next_acc = acc + (IVAL_W+16)'(1);
        end
    end

    logic [6:0] strobe_cnt;
    logic [6:0] next_strobe_cnt;
    always_comb begin
        next_strobe_cnt = (strobe_cnt != 7'h00) ? strobe_cnt - 7'h01 : 7'h00;
        if (fire) next_strobe_cnt = trigger_pulse_width;
    end

    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            dec_cnt <= 16'h0000;
            skip_cnt <= 16'h0000;
            acc <= '0;
            strobe_cnt <= 7'h00;
            o_trigger <= 1'b0;
        end else begin
            dec_cnt <= next_dec_cnt;
            skip_cnt <= next_skip_cnt;
            acc <= next_acc;
            strobe_cnt <= next_strobe_cnt;
            o_trigger <= (next_strobe_cnt != 7'h00);
        end
    end

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    a_method_reset: assert property (@(posedge i_clk)
        $past(i_reset) && !i_reset |->
        trigger_method_select == qelt_pkg::METHOD_RATIO)
        else $error("method not ratio after reset");
    a_masked_up: assert property (@(posedge i_clk) disable iff (i_reset)
        against && output_direction_policy != qelt_pkg::POLICY_MOTION &&
        ~&suppressed_pulse_count |=>
        suppressed_pulse_count == $past(suppressed_pulse_count) + 1'b1)
        else $error("masked count did not rise");
    a_masked_gate: assert property (@(posedge i_clk) disable iff (i_reset)
        suppressed_pulse_count != '0 |-> !pass_step)
        else $error("pulse passed while masked");
    a_motion_pass: assert property (@(posedge i_clk) disable iff (i_reset)
        output_direction_policy == qelt_pkg::POLICY_MOTION && any_edge
        |-> pass_step)
        else $error("motion edge dropped");
    a_skip_zero: assert property (@(posedge i_clk) disable iff (i_reset)
        trigger_method_select == qelt_pkg::METHOD_SKIP &&
        edges_to_skip == 16'h0000 && edge_pulse |-> fire)
        else $error("skip zero missed edge");
    a_ratio_one: assert property (@(posedge i_clk) disable iff (i_reset)
        trigger_method_select == qelt_pkg::METHOD_RATIO &&
        ratio_divider == qelt_pkg::RST_DIVIDER && a_pulse |-> fire)
        else $error("unit ratio missed pulse");
    a_ratio_only_a: assert property (@(posedge i_clk) disable iff (i_reset)
        trigger_method_select == qelt_pkg::METHOD_RATIO && is_whole &&
        fire |-> a_pulse)
        else $error("ratio fired without phase one rise");
    a_strobe_width: assert property (@(posedge i_clk) disable iff (i_reset)
        fire |=> o_trigger && strobe_cnt == trigger_pulse_width)
        else $error("strobe not started");

endmodule

// *** tb/qelt_encoder_model.sv ***
// Two-phase incremental encoder model for the line trigger bench.
// Assumes one step request per i_step pulse, steps spaced by the bench.
`timescale 1ns/100ps
module qelt_encoder_model (
    // Clock
    input wire logic i_clk,
    // Step request
    input wire logic i_step,
    input wire logic i_reverse,
    // Phase outputs
    output logic o_phase_a,
    output logic o_phase_b
);
    // ------------------------------------------------------------
    // Quadrature position
    // ------------------------------------------------------------
    logic [1:0] pos = 2'h0;

    always_ff @(posedge i_clk) begin
        if (i_step) begin
            pos <= i_reverse ? pos - 2'h1 : pos + 2'h1;
        end
    end

    // Gray order, phase one leads going forward
    assign o_phase_a = pos[0] ^ pos[1];
    assign o_phase_b = pos[1];
endmodule

// *** tb/qelt_trigger_bench.sv ***
// Self-checking bench for the encoder line trigger block.
// Assumes the encoder model file and the design package are compiled.
`timescale 1ns/100ps
module qelt_trigger_bench;
    // ------------------------------------------------------------
    // Signals
    // ------------------------------------------------------------
    logic i_clk = 1'b0;
    logic i_reset = 1'b1;
    logic [4:0] i_lines;
    logic [3:0] i_addr = 4'h0;
    logic [31:0] i_wdata = 32'h0000_0000;
    logic i_wr = 1'b0;
    logic i_rd = 1'b0;
    logic [31:0] o_rdata;
    logic o_trigger;
    logic o_direction;
    logic step = 1'b0;
    logic rev = 1'b0;
    logic glitch = 1'b0;
    logic pa;
    logic pb;
    logic rd_seen = 1'b0;
    logic [4:0] noise = 5'h00;
    logic [2:0] sel_a = 3'h0;
    logic [2:0] sel_b = 3'h2;
    logic [31:0] rd_q[$];
    logic [31:0] divs[4] = '{32'h0001_0000, 32'h0002_0000,
        32'h0000_8000, 32'h0000_8000};
    int gaps[4] = '{38, 38, 38, 23};
    int num_errors = 0;
    int checks = 0;
    int trig_cnt = 0;
    int wcnt = 0;
    int exp_width = 5;
    bit width_chk = 1'b1;

    // Unused lines carry noise so a wrong selection shows up
    always_comb begin
        i_lines = noise;
        i_lines[sel_a] = pa ^ glitch;
        i_lines[sel_b] = pb;
    end

    initial forever #10 i_clk = ~i_clk;

    qelt_trigger u_dut (.i_clk(i_clk), .i_reset(i_reset),
        .i_lines(i_lines), .i_addr(i_addr), .i_wdata(i_wdata),
        .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
        .o_trigger(o_trigger), .o_direction(o_direction));
    qelt_encoder_model u_enc (.i_clk(i_clk), .i_step(step),
        .i_reverse(rev), .o_phase_a(pa), .o_phase_b(pb));

    // ------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------
    task check(string name, logic [31:0] seen, logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("[FAIL] %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task bus(logic w, logic [3:0] a, logic [31:0] d);
        @(posedge i_clk);
        i_addr <= a;
        i_wdata <= d;
        i_wr <= w;
        i_rd <= !w;
        @(posedge i_clk);
        i_wr <= 1'b0;
        i_rd <= 1'b0;
    endtask

    task rd(logic [3:0] a, logic [31:0] e);
        rd_q.push_back(e);
        bus(1'b0, a, 32'h0000_0000);
    endtask

    // Steps spaced well apart so each trigger stands alone
    task steps(int n, logic r, int gap);
        repeat (n) begin
            @(posedge i_clk);
            step <= 1'b1;
            rev <= r;
            noise <= 5'($urandom);
            @(posedge i_clk);
            step <= 1'b0;
            repeat (gap) @(posedge i_clk);
        end
    endtask

    task count(int n, logic r, int gap, int e);
        trig_cnt = 0;
        steps(n, r, gap);
        repeat (8) @(posedge i_clk);
        check("triggers", 32'(trig_cnt), 32'(e));
    endtask

    task glitch_test(logic [31:0] filt, int len, int e);
        bus(1'b1, 4'h5, filt);
        repeat (12) @(posedge i_clk);
        trig_cnt = 0;
        glitch <= 1'b1;
        repeat (len) @(posedge i_clk);
        glitch <= 1'b0;
        repeat (20) @(posedge i_clk);
        check("glitch", 32'(trig_cnt), 32'(e));
    endtask

    task stop_test;
        $display("Errors: %0d, checks: %0d", num_errors, checks);
        if (num_errors == 0 && checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    // ------------------------------------------------------------
    // Output watcher
    // ------------------------------------------------------------
    always @(posedge i_clk) begin
        rd_seen <= i_rd;
        if (rd_seen) check("rdata", o_rdata, rd_q.pop_front());
        if (o_trigger) begin
            if (wcnt == 0) trig_cnt++;
            wcnt++;
        end else if (wcnt != 0) begin
            if (width_chk) check("width", 32'(wcnt), 32'(exp_width));
            wcnt = 0;
        end
    end

    // ------------------------------------------------------------
    // Sequence
    // ------------------------------------------------------------
    initial begin
        void'($urandom(69));
        repeat (12) @(posedge i_clk);
        i_reset <= 1'b0;
        rd(4'h0, 32'h0000_0020);
        rd(4'h1, 32'h0000_0000);
        rd(4'h2, 32'h0001_0000);
        rd(4'h6, 32'h0000_0005);
        rd(4'hA, 32'h0000_0001);
        rd(4'hF, 32'h0000_0000);
        for (int k = 0; k < 4; k++) begin
            bus(1'b1, 4'h2, divs[k]);
            // Synthesised pulses may restart a running strobe
            width_chk = (divs[k][15:0] == 16'h0000);
            steps(4, 1'b0, gaps[k]);
            count(16, 1'b0, gaps[k], 4 * 65536 / divs[k]);
        end
        exp_width = 1 + $urandom % 7;
        bus(1'b1, 4'h6, 32'(exp_width));
        bus(1'b1, 4'h1, 32'h0000_0001);
        bus(1'b1, 4'h0, 32'h0000_0043);
        sel_a <= 3'h3;
        sel_b <= 3'h4;
        rd(4'h0, 32'h0000_0043);
        repeat (20) @(posedge i_clk);
        width_chk = 1'b1;
        for (int s = 0; s < 3; s++) begin
            bus(1'b1, 4'h3, 32'(s));
            count(12, 1'($urandom), 38, 12 / (s + 1));
        end
        bus(1'b1, 4'h3, 32'h0000_0000);
        bus(1'b1, 4'h4, 32'h0000_0003);
        rd(4'h4, 32'h0000_0000);
        bus(1'b1, 4'h6, 32'h0000_0000);
        rd(4'h6, 32'h0000_0001);
        bus(1'b1, 4'h6, 32'(exp_width));
        bus(1'b1, 4'h7, 32'h0000_0002);
        rd(4'h7, 32'h0000_0002);
        bus(1'b1, 4'h8, 32'h0000_0123);
        rd(4'h8, 32'h0000_0123);
        // Short glitch must vanish; long one gives two separate strobes
        glitch_test(32'h0000_0007, 3, 0);
        glitch_test(32'h0000_0000, 10, 2);
        for (int p = 1; p < 3; p++) begin
            logic r;
            r = (p == 2);
            bus(1'b1, 4'h4, 32'(p));
            count(4, r, 10, 4);
            count(3, !r, 10, 0);
            rd(4'h9, 32'h0000_0003);
            rd(4'hA, {31'h0, r});
            check("direction", {31'h0, o_direction}, {31'h0, r});
            count(3, r, 10, 0);
            rd(4'h9, 32'h0000_0000);
            count(2, r, 10, 2);
        end
        stop_test;
    end

    // Whole run needs roughly 5000 cycles
    initial begin
        repeat (40000) @(posedge i_clk);
        num_errors++;
        stop_test;
    end
endmodule
